// file: logic/flash_prot_pkg.sv
package flash_prot_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_SUSP = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_KEY_LO = 8'h0C;
    localparam logic [7:0] OFS_KEY_HI = 8'h10;
    localparam logic [7:0] OFS_ARRAY_LOCK = 8'h14;
    localparam logic [7:0] OFS_SECT_SEL = 8'h18;
    localparam logic [7:0] OFS_PERS_ACC = 8'h1C;
    localparam logic [7:0] OFS_DYN_ACC = 8'h20;
    localparam logic [7:0] OFS_PERS_ERASE = 8'h24;
    // Field positions
    localparam int SUSP_ERASE_BIT = 1;
    localparam int SUSP_PROG_BIT = 0;
    localparam int UPPER_FOUR_BIT = 7;
    localparam int UPPER_BANK1_BIT = 1;
    localparam int UPPER_BANK0_BIT = 0;
    localparam int MODE_KEY_BIT = 2;
    localparam int MODE_PERS_BIT = 1;
    localparam int LOCK_BIT = 0;
    localparam int ERASE_GO_BIT = 0;
    localparam int CMD_ADDR_W = 24;
    localparam int BANK0_ADDR_BIT = 24;
    localparam int SECT_SHIFT = 16;
    // Reset and fixed values
    localparam logic [7:0] UPPER_RST = 8'h00;
    localparam logic [7:0] ACC_OPEN = 8'hFF;
    localparam logic [7:0] ACC_SHUT = 8'h00;
    localparam logic [15:0] MODE_RST_DEF = 16'hFFFF;
    localparam logic [63:0] KEY_RST = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [31:0] KEY_HIDDEN = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: logic/reg_access_if.sv
interface reg_access_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface

// file: logic/sector_lock_cell.sv
module sector_lock_cell (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bit updates
    input wire logic pers_clr,
    input wire logic pers_set,
    input wire logic dyn_clr,
    input wire logic dyn_set,
    // Lock bits, one means unprotected
    output logic pers_q,
    output logic dyn_q
);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pers_q <= 1'b1;
            dyn_q <= 1'b1;
        end else begin
            if (pers_clr) begin
                pers_q <= 1'b0;
            end else if (pers_set) begin
                pers_q <= 1'b1;
            end
            if (dyn_clr) begin
                dyn_q <= 1'b0;
            end else if (dyn_set) begin
                dyn_q <= 1'b1;
            end
        end
    end
endmodule // sector_lock_cell

// file: logic/axil_reg_slave.sv
module axil_reg_slave
    import flash_prot_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register file side
    reg_access_if.bus rif
);
    logic aw_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_fire = (aw_full_q || aw_hs) && (w_full_q || w_hs) && !s_axi_bvalid;
    wire ar_hs = s_axi_arvalid && s_axi_arready;

    // Address and data are taken in either order, one write at a time
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rif.wr_en = wr_fire;
    assign rif.wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
    assign rif.wr_data = w_full_q ? w_data_q : s_axi_wdata;
    assign rif.wr_strb = w_full_q ? w_strb_q : s_axi_wstrb;
    assign rif.rd_addr = s_axi_araddr;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rif.rd_data;
            s_axi_rresp <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // axil_reg_slave

// file: logic/flash_protect_addr_regs.sv
// Summary of operation
// - Erase-held flag mirrors erase suspend, read-only
// - Program-held flag mirrors program suspend, read-only
// - Four-byte enable passes full 32-bit address
// - Otherwise 24-bit address plus bank bits
// - Bank bit 0 is address bit 24
// - Bank bit 1 reserved, no address bit
// - Clearing mode bit 2 fixes key mode
// - Clearing mode bit 1 fixes persistent mode
// - 64-bit one-time key, erased all ones
// - Key unreadable once key mode chosen
// - Array lock zero refuses persistent changes
// - Array lock one allows persistent changes
// - Persistent byte 00h means sector protected
// - Persistent byte FFh means sector open
// - Dynamic write 00h protects the sector
// - Dynamic write FFh unprotects the sector

module flash_protect_addr_regs
    import flash_prot_pkg::*;
#(
    parameter int NUM_SECTORS = 512,
    parameter bit DENSITY_256 = 1'b1,
    parameter logic [15:0] MODE_INIT = MODE_RST_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Suspend state from the array sequencer
    input wire logic erase_held,
    input wire logic program_held,
    // Command address translation
    input wire logic [31:0] cmd_addr,
    input wire logic cmd_addr_valid,
    output logic four_byte_addr_enable,
    output logic [31:0] full_addr_q,
    output logic full_addr_valid_q,
    // Program or erase permission check
    input wire logic [31:0] op_addr,
    input wire logic op_check,
    output logic op_allowed_q,
    output logic op_result_valid_q
);
    localparam int SECT_W = $clog2(NUM_SECTORS);

    reg_access_if rif ();

    axil_reg_slave u_slave (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rif(rif)
    );

    logic [7:0] upper_q;
    logic [15:0] mode_q;
    logic [63:0] key_q;
    logic array_lock_q;
    logic [SECT_W-1:0] sect_sel_q;
    logic [NUM_SECTORS-1:0] pers_vec;
    logic [NUM_SECTORS-1:0] dyn_vec;

    // Write decode
    wire lane0 = rif.wr_strb[0];
    wire wr_upper = rif.wr_en && rif.wr_addr == OFS_UPPER && lane0;
    wire wr_mode = rif.wr_en && rif.wr_addr == OFS_MODE;
    wire wr_key_lo = rif.wr_en && rif.wr_addr == OFS_KEY_LO;
    wire wr_key_hi = rif.wr_en && rif.wr_addr == OFS_KEY_HI;
    wire wr_lock = rif.wr_en && rif.wr_addr == OFS_ARRAY_LOCK && lane0;
    wire wr_sel = rif.wr_en && rif.wr_addr == OFS_SECT_SEL;
    wire wr_pers = rif.wr_en && rif.wr_addr == OFS_PERS_ACC && lane0;
    wire wr_dyn = rif.wr_en && rif.wr_addr == OFS_DYN_ACC && lane0;
    wire wr_erase = rif.wr_en && rif.wr_addr == OFS_PERS_ERASE && lane0;
    wire wr_known = wr_upper || wr_mode || wr_key_lo || wr_key_hi || wr_lock
        || wr_sel || wr_pers || wr_dyn || wr_erase || rif.wr_addr == OFS_SUSP;
    assign rif.wr_err = !wr_known;

    // Byte mask from strobes: unstrobed lanes keep their OTP state
    wire [31:0] keep_mask = {{8{!rif.wr_strb[3]}}, {8{!rif.wr_strb[2]}},
                             {8{!rif.wr_strb[1]}}, {8{!rif.wr_strb[0]}}};
    wire [31:0] otp_word = rif.wr_data | keep_mask;
    wire key_mode_on = !mode_q[MODE_KEY_BIT];
    wire [7:0] wr_byte = rif.wr_data[7:0];

    // Upper address register, reserved bits never stored
    // bank bit 0 only on the large density
    wire bank0_w = DENSITY_256 ? wr_byte[UPPER_BANK0_BIT] : 1'b0;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            upper_q <= UPPER_RST;
        end else if (wr_upper) begin
            upper_q <= {wr_byte[UPPER_FOUR_BIT], 6'h00, bank0_w};
        end
    end

    // OTP bits only move from one to zero
    // same for the persistent mode bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= MODE_INIT;
        end else if (wr_mode) begin
            mode_q <= mode_q & otp_word[15:0];
        end
    end

    // key programs only toward zero, frozen in key mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            key_q <= KEY_RST;
        end else if (wr_key_lo && !key_mode_on) begin
            key_q[31:0] <= key_q[31:0] & otp_word;
        end else if (wr_key_hi && !key_mode_on) begin
            key_q[63:32] <= key_q[63:32] & otp_word;
        end
    end

    // lock defaults open in persistent mode, shut in key mode
    // once cleared it stays until reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            array_lock_q <= MODE_INIT[MODE_KEY_BIT];
        end else if (wr_lock && !wr_byte[LOCK_BIT]) begin
            array_lock_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sect_sel_q <= '0;
        end else if (wr_sel) begin
            sect_sel_q <= rif.wr_data[SECT_W-1:0];
        end
    end

    // Per-sector lock bits; other byte values are ignored
    // 00h programs the persistent bit when unlocked
    wire pers_prog = wr_pers && wr_byte == ACC_SHUT && array_lock_q;
    wire pers_wipe = wr_erase && rif.wr_data[ERASE_GO_BIT] && array_lock_q;

    // 00h clears, FFh sets the dynamic bit
    wire dyn_clr = wr_dyn && wr_byte == ACC_SHUT;
    wire dyn_set = wr_dyn && wr_byte == ACC_OPEN;

    for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_sect
        wire hit = sect_sel_q == SECT_W'(i);
        sector_lock_cell u_cell (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .pers_clr(pers_prog && hit),
            .pers_set(pers_wipe),
            .dyn_clr(dyn_clr && hit),
            .dyn_set(dyn_set && hit),
            .pers_q(pers_vec[i]),
            .dyn_q(dyn_vec[i])
        );
    end

    // Read decode
    // live suspend state, upper bits zero
    wire [31:0] susp_rd = {30'h0, erase_held, program_held};

    // key hidden once key mode is chosen
    wire [31:0] key_lo_rd = key_mode_on ? KEY_HIDDEN : key_q[31:0];
    wire [31:0] key_hi_rd = key_mode_on ? KEY_HIDDEN : key_q[63:32];

    // access bytes read 00h or FFh
    wire [7:0] pers_rd = pers_vec[sect_sel_q] ? ACC_OPEN : ACC_SHUT;
    wire [7:0] dyn_rd = dyn_vec[sect_sel_q] ? ACC_OPEN : ACC_SHUT;

    logic [31:0] rd_mux;
    logic rd_bad;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b0;
        case (rif.rd_addr)
            OFS_SUSP: rd_mux = susp_rd;
            OFS_UPPER: rd_mux = {24'h0, upper_q};
            OFS_MODE: rd_mux = {16'h0, mode_q};
            OFS_KEY_LO: rd_mux = key_lo_rd;
            OFS_KEY_HI: rd_mux = key_hi_rd;
            OFS_ARRAY_LOCK: rd_mux = {31'h0, array_lock_q};
            OFS_SECT_SEL: rd_mux = 32'(sect_sel_q);
            OFS_PERS_ACC: rd_mux = {24'h0, pers_rd};
            OFS_DYN_ACC: rd_mux = {24'h0, dyn_rd};
            OFS_PERS_ERASE: rd_mux = 32'h0000_0000;
            default: rd_bad = 1'b1;
        endcase
    end
    assign rif.rd_data = rd_mux;
    assign rif.rd_err = rd_bad;

    // Address extension
    assign four_byte_addr_enable = upper_q[UPPER_FOUR_BIT];
    wire [31:0] bank_addr = {7'h00, upper_q[UPPER_BANK0_BIT], cmd_addr[CMD_ADDR_W-1:0]};

    // full address from host, bank supplies top bits
    wire [31:0] addr_d = four_byte_addr_enable ? cmd_addr : bank_addr;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            full_addr_q <= 32'h0000_0000;
            full_addr_valid_q <= 1'b0;
        end else begin
            full_addr_valid_q <= cmd_addr_valid;
            if (cmd_addr_valid) begin
                full_addr_q <= addr_d;
            end
        end
    end

    // Sector of an operation; addresses beyond the array wrap by index width
    wire [SECT_W-1:0] op_sect = op_addr[SECT_SHIFT +: SECT_W];
    wire op_ok = pers_vec[op_sect] && dyn_vec[op_sect];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            op_allowed_q <= 1'b0;
            op_result_valid_q <= 1'b0;
        end else begin
            op_result_valid_q <= op_check;
            if (op_check) begin
                op_allowed_q <= op_ok;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    wire ar_take = s_axi_arvalid && s_axi_arready;

    chk_susp_erase: assert property (
        ar_take && s_axi_araddr == OFS_SUSP |=>
            s_axi_rdata[SUSP_ERASE_BIT] == $past(erase_held))
        else $error("erase-held flag read wrong");

    chk_susp_prog: assert property (
        ar_take && s_axi_araddr == OFS_SUSP |=>
            s_axi_rdata[SUSP_PROG_BIT] == $past(program_held) && s_axi_rvalid)
        else $error("program-held flag read wrong");

    chk_addr_full: assert property (
        cmd_addr_valid && four_byte_addr_enable |=>
            full_addr_valid_q && full_addr_q == $past(cmd_addr))
        else $error("four-byte address not passed");

    chk_addr_bank: assert property (
        cmd_addr_valid && !four_byte_addr_enable |=>
            full_addr_q[23:0] == $past(cmd_addr[23:0]) && full_addr_q[31:25] == 7'h00)
        else $error("three-byte address wrong");

    chk_bank_bit: assert property (
        cmd_addr_valid && !four_byte_addr_enable |=>
            full_addr_q[BANK0_ADDR_BIT] == ($past(upper_q[UPPER_BANK0_BIT]) && DENSITY_256))
        else $error("bank bit 0 not on address bit 24");

    chk_bank1_rsvd: assert property (
        wr_upper |=> upper_q[UPPER_BANK1_BIT] == 1'b0 && upper_q[6:2] == 5'h00)
        else $error("reserved bank bit stored");

    chk_key_mode: assert property (
        !mode_q[MODE_KEY_BIT] |=> !mode_q[MODE_KEY_BIT])
        else $error("key mode bit returned to one");

    chk_persist_mode: assert property (
        wr_mode && !rif.wr_data[MODE_PERS_BIT] && rif.wr_strb[0] |=> !mode_q[MODE_PERS_BIT])
        else $error("persistent mode bit not cleared");

    chk_key_hidden: assert property (
        ar_take && key_mode_on && (s_axi_araddr == OFS_KEY_LO || s_axi_araddr == OFS_KEY_HI)
            |=> s_axi_rdata == KEY_HIDDEN)
        else $error("key readable in key mode");

    chk_array_frozen: assert property (
        !array_lock_q |=> $stable(pers_vec) && !array_lock_q)
        else $error("persistent array changed while locked");

    chk_pers_prog: assert property (
        wr_pers && wr_byte == ACC_SHUT && array_lock_q |=> !pers_vec[sect_sel_q])
        else $error("persistent bit not programmed");

    chk_dyn_write: assert property (
        dyn_clr |=> !dyn_vec[$past(sect_sel_q)] ##1 $stable(dyn_vec) || wr_dyn || wr_sel)
        else $error("dynamic bit not cleared");

    chk_dyn_open: assert property (
        dyn_set |=> dyn_vec[$past(sect_sel_q)])
        else $error("dynamic bit not set");

    chk_op_allow: assert property (
        op_check |=> op_result_valid_q && op_allowed_q == $past(op_ok))
        else $error("permission not both bits");

    chk_pers_erase: assert property (
        pers_wipe |=> &pers_vec)
        else $error("persistent array not erased");

    chk_key_frozen: assert property (
        key_mode_on |=> $stable(key_q))
        else $error("key changed in key mode");

    chk_lock_open: assert property (
        array_lock_q && !wr_lock |=> array_lock_q)
        else $error("array lock cleared unasked");

    wire wr_fire_c = rif.wr_en;
    cov_write_resp: cover property (wr_fire_c ##[1:4] s_axi_bvalid && s_axi_bready);
    cov_key_mode: cover property ($fell(mode_q[MODE_KEY_BIT]));
    cov_op_blocked: cover property (op_check ##1 !op_allowed_q);
    cov_four_byte: cover property (cmd_addr_valid && four_byte_addr_enable);
    cov_lock_shut: cover property ($fell(array_lock_q));
endmodule // flash_protect_addr_regs

// file: dv/host_side_model.sv
module host_side_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Requests from the bench
    input wire logic send,
    input wire logic [31:0] host_addr,
    input wire logic susp_erase,
    input wire logic susp_prog,
    // Mode seen from the device
    input wire logic four_byte_addr_enable,
    // Lines toward the device
    output logic [31:0] cmd_addr,
    output logic cmd_addr_valid,
    output logic erase_held,
    output logic program_held
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_addr <= 32'h0000_0000;
            cmd_addr_valid <= 1'b0;
            erase_held <= 1'b0;
            program_held <= 1'b0;
        end else begin
            cmd_addr_valid <= send;
            // full address width
            // Short form leaves top byte undriven, shown inverted so stale bits never pass
            cmd_addr <= four_byte_addr_enable ? host_addr : {~host_addr[31:24], host_addr[23:0]};
            erase_held <= susp_erase;
            program_held <= susp_prog;
        end
    end
endmodule // host_side_model

// file: dv/tb_top.sv
module tb_top
    import flash_prot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0, sys_rst = 1'b1, send = 1'b0, susp_erase = 1'b0, susp_prog = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_check = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, host_addr = 32'h0, op_addr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, cmd_addr, full_addr_q;
    logic cmd_addr_valid, erase_held, program_held, four_byte_addr_enable;
    logic full_addr_valid_q, op_allowed_q, op_result_valid_q;
    int err_count = 0;
    int comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    flash_protect_addr_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .erase_held(erase_held),
        .program_held(program_held), .cmd_addr(cmd_addr), .cmd_addr_valid(cmd_addr_valid),
        .four_byte_addr_enable(four_byte_addr_enable), .full_addr_q(full_addr_q),
        .full_addr_valid_q(full_addr_valid_q), .op_addr(op_addr), .op_check(op_check),
        .op_allowed_q(op_allowed_q), .op_result_valid_q(op_result_valid_q));

    host_side_model i_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .send(send),
        .host_addr(host_addr), .susp_erase(susp_erase), .susp_prog(susp_prog),
        .four_byte_addr_enable(four_byte_addr_enable), .cmd_addr(cmd_addr),
        .cmd_addr_valid(cmd_addr_valid), .erase_held(erase_held), .program_held(program_held));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Ready is looked at 1 ns after an edge, so it is the value the next edge samples
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, bv;
        logic [1:0] br;
        bv = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bv) begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check(bv, 1'b1);
        check(br, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, rv;
        logic [31:0] rd;
        logic [1:0] rr;
        rv = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rv) begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check(rv, 1'b1);
        check(rd, exp);
        check(rr, er);
    endtask

    task automatic addr_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        send <= 1'b1;
        host_addr <= a;
        @(posedge clk_sys);
        send <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(full_addr_valid_q, 1'b1);
        check(full_addr_q, exp);
    endtask

    task automatic op_chk(input logic [31:0] a, input logic exp);
        @(posedge clk_sys);
        op_addr <= a;
        op_check <= 1'b1;
        @(posedge clk_sys);
        op_check <= 1'b0;
        #1;
        check(op_result_valid_q, 1'b1);
        check(op_allowed_q, exp);
    endtask

    task automatic t_reset();
        rd_chk(OFS_SUSP, 32'h0, RESP_OKAY);
        rd_chk(OFS_UPPER, 32'h0, RESP_OKAY);
        rd_chk(OFS_MODE, 32'h0000_FFFF, RESP_OKAY);
        rd_chk(OFS_KEY_LO, 32'hFFFF_FFFF, RESP_OKAY);
        rd_chk(OFS_KEY_HI, 32'hFFFF_FFFF, RESP_OKAY);
        rd_chk(OFS_ARRAY_LOCK, 32'h1, RESP_OKAY);
        rd_chk(OFS_PERS_ACC, 32'hFF, RESP_OKAY);
        rd_chk(OFS_DYN_ACC, 32'hFF, RESP_OKAY);
        rd_chk(8'hFC, 32'h0, RESP_SLVERR);
        axi_wr(8'hFC, 32'h0, RESP_SLVERR);
    endtask

    task automatic t_suspend();
        axi_wr(OFS_SUSP, 32'h3, RESP_OKAY);
        rd_chk(OFS_SUSP, 32'h0, RESP_OKAY);
        susp_erase <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk(OFS_SUSP, 32'h2, RESP_OKAY);
        susp_erase <= 1'b0;
        susp_prog <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk(OFS_SUSP, 32'h1, RESP_OKAY);
        susp_prog <= 1'b0;
    endtask

    task automatic t_addr();
        axi_wr(OFS_UPPER, 32'h3, RESP_OKAY);
        rd_chk(OFS_UPPER, 32'h1, RESP_OKAY);
        check(four_byte_addr_enable, 1'b0);
        addr_chk(32'hAB12_3456, 32'h0112_3456);
        axi_wr(OFS_UPPER, 32'h0, RESP_OKAY);
        addr_chk(32'hFFFF_FFFF, 32'h00FF_FFFF);
        axi_wr(OFS_UPPER, 32'h80, RESP_OKAY);
        check(four_byte_addr_enable, 1'b1);
        addr_chk(32'hAB12_3456, 32'hAB12_3456);
    endtask

    task automatic t_sector();
        axi_wr(OFS_SECT_SEL, 32'h3, RESP_OKAY);
        axi_wr(OFS_PERS_ACC, 32'h0, RESP_OKAY);
        rd_chk(OFS_PERS_ACC, 32'h0, RESP_OKAY);
        op_chk(32'h0003_0000, 1'b0);
        op_chk(32'h0004_0000, 1'b1);
        axi_wr(OFS_PERS_ERASE, 32'h1, RESP_OKAY);
        rd_chk(OFS_PERS_ACC, 32'hFF, RESP_OKAY);
        axi_wr(OFS_DYN_ACC, 32'h0, RESP_OKAY);
        rd_chk(OFS_DYN_ACC, 32'h0, RESP_OKAY);
        op_chk(32'h0003_0000, 1'b0);
        axi_wr(OFS_DYN_ACC, 32'hFF, RESP_OKAY);
        rd_chk(OFS_DYN_ACC, 32'hFF, RESP_OKAY);
        op_chk(32'h0003_0000, 1'b1);
    endtask

    task automatic t_lock();
        axi_wr(OFS_ARRAY_LOCK, 32'h0, RESP_OKAY);
        rd_chk(OFS_ARRAY_LOCK, 32'h0, RESP_OKAY);
        axi_wr(OFS_PERS_ACC, 32'h0, RESP_OKAY);
        rd_chk(OFS_PERS_ACC, 32'hFF, RESP_OKAY);
        op_chk(32'h0003_0000, 1'b1);
        // Lock holds until a hardware reset only
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(OFS_ARRAY_LOCK, 32'h1, RESP_OKAY);
    endtask

    task automatic t_key();
        axi_wr(OFS_KEY_LO, 32'h1234_5678, RESP_OKAY);
        rd_chk(OFS_KEY_LO, 32'h1234_5678, RESP_OKAY);
        axi_wr(OFS_MODE, 32'h0000_FFFD, RESP_OKAY);
        rd_chk(OFS_MODE, 32'h0000_FFFD, RESP_OKAY);
        rd_chk(OFS_KEY_LO, 32'h1234_5678, RESP_OKAY);
        axi_wr(OFS_MODE, 32'h0000_FFF9, RESP_OKAY);
        axi_wr(OFS_MODE, 32'h0000_FFFF, RESP_OKAY);
        rd_chk(OFS_MODE, 32'h0000_FFF9, RESP_OKAY);
        rd_chk(OFS_KEY_LO, KEY_HIDDEN, RESP_OKAY);
        rd_chk(OFS_KEY_HI, KEY_HIDDEN, RESP_OKAY);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_suspend();
        t_addr();
        t_sector();
        t_lock();
        t_key();
        stop_test();
    end

    // Whole run needs under two hundred cycles
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // tb_top
